// file: design/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
    $error("depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_s;

  fifo_s            st;
  fifo_s            next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (st.wp - st.rp) != (AW+1)'(DEPTH);
  assign out_valid = st.wp != st.rp;
  assign out_data  = mem[st.rp[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push)
      next_st.wp = st.wp + 1'b1;
    if (pop)
      next_st.rp = st.rp + 1'b1;
    if (flush)
      next_st = '0;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
    if (push)
      mem[st.wp[AW-1:0]] <= in_data;
  end
endmodule // byte_fifo

// file: design/usb_ep_device.sv
`timescale 1ns/1ps
// What this block does
// (R1) selector low nibble picks endpoint zero to three
// (R2) low speed needs a 6 MHz clock
// (R3) full speed needs a 48 MHz clock
// (R4) speed comes from transceiver control bit
// (R5) recovery enable bit gates oscillator trimming and single step, not low speed recovery
// (R6) software sets low speed recovery bit
// (R7) single step bit selects stepwise calibration
// (R8) software writes 01111b into reserved bits
// (R9) 1024 byte ram holds all endpoint fifos
// (R10) endpoints one to three: in, out, split
// (R11) split: upper half in, lower half out
// (R12) unsplit halves merge into one direction
// (R13) merged direction follows direction select bit
// (R14) double buffering halves maximum packet size
// (R15) endpoint zero is always single buffered
// (R16) split halves choose double buffering separately
// (R17) packet sizes 128, 256, 512 then halved
// (R18) data port read pops, write pushes
// (R19) bus reset clears endpoint selector
// (R20) reserved selector blocks indexed access, reads zero
module usb_ep_device
  import usb_ep_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // register port
  usb_reg_if.device         regs,
  // transceiver and oscillator controls
  input  wire logic         transceiver_speed,
  output logic              low_speed_mode,
  output logic              trim_enable,
  output logic              trim_single_step,
  output logic              trim_low_speed,
  // usb side byte streams to and from the endpoints
  output logic              usb_out_valid,
  input  wire logic         usb_out_ready,
  output logic        [7:0] usb_out_data,
  output logic        [1:0] usb_out_endpoint,
  input  wire logic         usb_in_valid,
  output logic              usb_in_ready,
  input  wire logic   [7:0] usb_in_data,
  input  wire logic   [1:0] usb_in_endpoint,
  // current endpoint layout
  output logic              endpoint_valid,
  output logic        [1:0] endpoint_pick,
  output logic       [10:0] max_in_packet,
  output logic       [10:0] max_out_packet
);
  import usb_ep_pkg::*;

  typedef struct packed {
    logic [3:0]      selector;
    logic [7:0]      clock_recovery_control;
    logic [3:0][7:0] in_csr_high;
    logic [3:0][7:0] out_csr_high;
    logic [3:0][2:0] layout;
    logic [3:0][10:0] in_wp;
    logic [3:0][10:0] in_rp;
    logic [3:0][10:0] out_wp;
    logic [3:0][10:0] out_rp;
    logic [7:0]      rdata;
    logic            ack;
  } dev_s;

  dev_s       st;
  dev_s       next_st;
  logic [7:0] ram [FIFO_RAM_BYTES];
  logic       ram_we;
  logic [9:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [7:0] rx_data;
  logic [9:0] ram_raddr;
  logic       stage_valid;
  logic       stage_ready;
  logic [1:0] rx_ep;
  logic [1:0] host_ep;
  logic       sel_ok;
  logic       port_hit;

  // split-aware half-region base and length of one direction
  function automatic logic [10:0] dir_base(input logic [1:0] ep,
                                           input logic in_dir,
                                           input logic split);
    logic [10:0] b;
    b = EP_BASE[ep];
    if (split && in_dir && ep != 2'd0)
      b = b + (EP_SIZE[ep] >> 1); // [R11]
    return b;
  endfunction

  function automatic logic [10:0] dir_len(input logic [1:0] ep,
                                          input logic split);
    return (split && ep != 2'd0) ? (EP_SIZE[ep] >> 1) : EP_SIZE[ep];
  endfunction

  // a merged fifo on endpoints one to three carries one direction only
  function automatic logic dir_allowed(input logic [1:0] ep,
                                       input logic in_dir,
                                       input dev_s s);
    if (ep == 2'd0 || s.layout[ep][SPLIT_BIT])
      return 1'b1;
    return s.in_csr_high[ep][FIFO_DIRECTION_BIT] == in_dir; // [R12] [R13]
  endfunction

  assign sel_ok        = st.selector <= LAST_ENDPOINT;
  assign host_ep       = st.selector[1:0];
  assign port_hit      = regs.addr >= ADDR_DATA_PORT_BASE
                         && regs.addr <= ADDR_DATA_PORT_LAST;
  assign endpoint_valid = sel_ok;
  assign endpoint_pick = host_ep;
  assign low_speed_mode = !transceiver_speed; // [R4]
  assign trim_enable   = st.clock_recovery_control[RECOVERY_ENABLE_BIT]; // [R5]
  assign trim_single_step = st.clock_recovery_control[RECOVERY_ENABLE_BIT]
                            && st.clock_recovery_control[RECOVERY_SINGLE_STEP_BIT]; // [R7]
  assign trim_low_speed = st.clock_recovery_control[LOW_SPEED_RECOVERY_BIT];
  assign max_in_packet = max_packet(host_ep, st.layout[host_ep][SPLIT_BIT],
                           st.layout[host_ep][DOUBLE_BUF_BIT]); // [R14] [R17]
  assign max_out_packet = max_packet(host_ep,
                           st.layout[host_ep][SPLIT_BIT],
                           st.layout[host_ep][SPLIT_BIT]
                           ? st.out_csr_high[host_ep][OUT_DOUBLE_BUF_BIT]
                           : st.layout[host_ep][DOUBLE_BUF_BIT]); // [R16]
  assign regs.rdata    = st.rdata;
  assign regs.ack      = st.ack;

  // incoming usb bytes are staged so a full or wrong-direction OUT area can stall the link
  byte_fifo #(.WIDTH(10), .DEPTH(4)) byte_fifo_inst (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .flush     (regs.bus_reset),
    .in_valid  (usb_in_valid),
    .in_ready  (usb_in_ready),
    .in_data   ({usb_in_endpoint, usb_in_data}),
    .out_valid (stage_valid),
    .out_ready (stage_ready),
    .out_data  ({rx_ep, rx_data})
  );

  always_comb begin
    logic [10:0] len;
    logic [10:0] fill;
    logic [1:0]  e;
    len = '0;
    fill = '0;
    e = usb_out_endpoint;
    next_st = st;
    next_st.ack = 1'b0;
    ram_we = 1'b0;
    ram_waddr = '0;
    ram_wdata = '0;
    ram_raddr = '0;
    stage_ready = 1'b0;
    usb_out_valid = 1'b0;
    // usb side: host OUT bytes land in the OUT area
    len = dir_len(rx_ep, st.layout[rx_ep][SPLIT_BIT]);
    fill = st.out_wp[rx_ep] - st.out_rp[rx_ep];
    if (stage_valid && fill != len && dir_allowed(rx_ep, 1'b0, st)) begin
      stage_ready = 1'b1;
      ram_we = 1'b1;
      ram_wdata = rx_data;
      ram_waddr = 10'(dir_base(rx_ep, 1'b0, st.layout[rx_ep][SPLIT_BIT])
                  + (st.out_wp[rx_ep] % len)); // [R9]
      next_st.out_wp[rx_ep] = st.out_wp[rx_ep] + 11'd1;
    end
    // usb side: IN area drained toward the host
    usb_out_valid = st.in_wp[e] != st.in_rp[e];
    if (usb_out_valid && usb_out_ready)
      next_st.in_rp[e] = st.in_rp[e] + 11'd1;
    // register port
    if (regs.req && !st.ack) begin
      next_st.ack = 1'b1;
      next_st.rdata = 8'h00;
      if (regs.wr) begin
        unique case (regs.addr)
          ADDR_ENDPOINT_SELECTOR:
            next_st.selector = regs.wdata[ENDPOINT_PICK_MSB:0]; // [R1]
          ADDR_CLOCK_RECOVERY:
            next_st.clock_recovery_control = regs.wdata; // [R6] [R8]
          ADDR_EP_IN_CSR_HIGH:
            if (sel_ok)
              next_st.in_csr_high[host_ep] = regs.wdata; // [R20]
          ADDR_EP_OUT_CSR_HIGH:
            if (sel_ok)
              next_st.out_csr_high[host_ep] = regs.wdata; // [R20]
          ADDR_FIFO_LAYOUT:
            if (sel_ok && host_ep != 2'd0)
              next_st.layout[host_ep] = regs.wdata[2:0]; // [R10] [R15]
          default: ;
        endcase
      end else begin
        unique case (regs.addr)
          ADDR_ENDPOINT_SELECTOR: next_st.rdata = {4'h0, st.selector};
          ADDR_CLOCK_RECOVERY:    next_st.rdata = st.clock_recovery_control;
          ADDR_EP_IN_CSR_HIGH:
            next_st.rdata = sel_ok ? st.in_csr_high[host_ep] : 8'h00;
          ADDR_EP_OUT_CSR_HIGH:
            next_st.rdata = sel_ok ? st.out_csr_high[host_ep] : 8'h00;
          ADDR_EP_OUT_COUNT_LOW:
            next_st.rdata = sel_ok ? 8'(st.out_wp[host_ep]
                                        - st.out_rp[host_ep]) : 8'h00;
          ADDR_EP_OUT_COUNT_HIGH:
            next_st.rdata = sel_ok ? {5'h0, 3'((st.out_wp[host_ep]
                             - st.out_rp[host_ep]) >> 8)} : 8'h00;
          ADDR_FIFO_LAYOUT:
            next_st.rdata = sel_ok ? {5'h0, st.layout[host_ep]} : 8'h00;
          default: ;
        endcase
      end
      if (port_hit) begin
        e = regs.addr[1:0];
        len = dir_len(e, st.layout[e][SPLIT_BIT]);
        if (regs.wr) begin
          fill = st.in_wp[e] - st.in_rp[e];
          if (fill != len && dir_allowed(e, 1'b1, st) && !ram_we) begin
            ram_we = 1'b1;
            ram_wdata = regs.wdata;
            ram_waddr = 10'(dir_base(e, 1'b1, st.layout[e][SPLIT_BIT])
                        + (st.in_wp[e] % len)); // [R18]
            next_st.in_wp[e] = st.in_wp[e] + 11'd1;
          end else if (ram_we) begin
            next_st.ack = 1'b0; // ram busy, retried next cycle
          end
        end else if (st.out_wp[e] != st.out_rp[e]) begin
          next_st.rdata = ram[10'(dir_base(e, 1'b0,
                            st.layout[e][SPLIT_BIT])
                            + (st.out_rp[e] % len))]; // [R18]
          next_st.out_rp[e] = st.out_rp[e] + 11'd1;
        end
      end
    end
    if (regs.bus_reset) begin
      next_st.selector = RST_ENDPOINT_SELECTOR[3:0]; // [R19]
      next_st.in_wp = '0;
      next_st.in_rp = '0;
      next_st.out_wp = '0;
      next_st.out_rp = '0;
      next_st.in_csr_high = '0;
      next_st.out_csr_high = '0;
    end
    // fetch the byte the drain side shows next cycle, so data stays
    // aligned with valid even when a byte is taken every cycle
    e = next_st.selector[1:0];
    ram_raddr = 10'(dir_base(e, 1'b1, next_st.layout[e][SPLIT_BIT])
                + (next_st.in_rp[e]
                   % dir_len(e, next_st.layout[e][SPLIT_BIT])));
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
      st.clock_recovery_control <= RST_CLOCK_RECOVERY;
    end else begin
      st <= next_st;
    end
    if (ram_we)
      ram[ram_waddr] <= ram_wdata;
    // a byte written this cycle at the fetched slot is passed straight on
    usb_out_data <= (ram_we && ram_waddr == ram_raddr) ? ram_wdata
                                                        : ram[ram_raddr];
  end

  always_comb begin
    // the usb-side endpoint for IN draining follows the selector
    usb_out_endpoint = host_ep;
  end
endmodule // usb_ep_device

// file: design/usb_ep_host.sv
`timescale 1ns/1ps
module usb_ep_host
  import usb_ep_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       nrst,
  // register port of the device
  usb_reg_if.host         regs,
  // user command side
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       cmd_bus_reset,
  output logic            rsp_valid,
  output logic      [7:0] rsp_data
);
  import usb_ep_pkg::*;

  typedef struct packed {
    host_state_e state;
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        bus_reset;
  } host_s;

  host_s st;
  host_s next_st;

  assign cmd_ready       = st.state == HOST_IDLE;
  assign regs.req        = st.state == HOST_WRITE || st.state == HOST_READ;
  assign regs.wr         = st.wr;
  assign regs.addr       = st.addr;
  assign regs.wdata      = st.wdata;
  assign regs.bus_reset  = st.bus_reset;
  assign rsp_valid       = st.rsp_valid;
  assign rsp_data        = st.rsp_data;

  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    next_st.bus_reset = cmd_bus_reset;
    unique case (st.state)
      HOST_IDLE:
        if (cmd_valid) begin
          next_st.wr = cmd_write;
          next_st.addr = cmd_addr;
          // reserved recovery bits always carry their fixed pattern
          next_st.wdata = (cmd_addr == ADDR_CLOCK_RECOVERY)
                          ? {cmd_wdata[7:5], RST_CLOCK_RECOVERY[4:0]}
                          : cmd_wdata; // [R8]
          next_st.state = cmd_write ? HOST_WRITE : HOST_READ;
        end
      HOST_WRITE, HOST_READ:
        if (regs.ack) begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data = st.wr ? 8'h00 : regs.rdata;
          next_st.state = HOST_WAIT;
        end
      HOST_WAIT:
        next_st.state = HOST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst)
      st <= '{state: HOST_IDLE, default: '0};
    else
      st <= next_st;
  end
endmodule // usb_ep_host

// file: design/usb_ep_pkg.sv
package usb_ep_pkg;
  // register offsets (byte addresses on the controller's own register port)
  localparam logic [7:0] ADDR_ENDPOINT_SELECTOR   = 8'h0e;
  localparam logic [7:0] ADDR_CLOCK_RECOVERY      = 8'h0f;
  localparam logic [7:0] ADDR_EP_IN_CSR_HIGH      = 8'h12;
  localparam logic [7:0] ADDR_EP_OUT_CSR_LOW      = 8'h14;
  localparam logic [7:0] ADDR_EP_OUT_CSR_HIGH     = 8'h15;
  localparam logic [7:0] ADDR_EP_OUT_COUNT_LOW    = 8'h16;
  localparam logic [7:0] ADDR_EP_OUT_COUNT_HIGH   = 8'h17;
  localparam logic [7:0] ADDR_DATA_PORT_BASE      = 8'h20;
  localparam logic [7:0] ADDR_DATA_PORT_LAST      = 8'h23;
  // register added for the fifo layout bits
  localparam logic [7:0] ADDR_FIFO_LAYOUT         = 8'h1f;

  // reset values
  localparam logic [7:0] RST_ENDPOINT_SELECTOR    = 8'h00;
  localparam logic [7:0] RST_CLOCK_RECOVERY       = 8'h0f;

  // field positions
  localparam int ENDPOINT_PICK_MSB        = 3;
  localparam int RECOVERY_ENABLE_BIT      = 7;
  localparam int RECOVERY_SINGLE_STEP_BIT = 6;
  localparam int LOW_SPEED_RECOVERY_BIT   = 5;
  localparam int FIFO_DIRECTION_BIT       = 5;
  localparam int SPLIT_BIT                = 2;
  localparam int DOUBLE_BUF_BIT           = 1;
  localparam int OUT_DOUBLE_BUF_BIT       = 1;

  localparam logic [3:0] LAST_ENDPOINT    = 4'h3;
  localparam int FIFO_RAM_BYTES           = 1024;

  // fifo region bases and single-buffered sizes per endpoint
  localparam logic [10:0] EP_BASE [4]     = '{11'h000, 11'h040,
                                              11'h0c0, 11'h1c0};
  localparam logic [10:0] EP_SIZE [4]     = '{11'h040, 11'h080,
                                              11'h100, 11'h200};

  typedef enum logic [1:0] {
    HOST_IDLE  = 2'b00,
    HOST_WRITE = 2'b01,
    HOST_READ  = 2'b10,
    HOST_WAIT  = 2'b11
  } host_state_e;

  function automatic logic [10:0] max_packet(
    input logic [1:0] ep,
    input logic       split,
    input logic       dbl
  );
    logic [10:0] size;
    size = EP_SIZE[ep];
    if (split && ep != 2'd0)
      size = size >> 1;
    if (dbl && ep != 2'd0)
      size = size >> 1;
    return size;
  endfunction
endpackage

// file: design/usb_reg_if.sv
`timescale 1ns/1ps
interface usb_reg_if;
  logic       req;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;
  logic       bus_reset;

  modport device (
    input  req, wr, addr, wdata, bus_reset,
    output rdata, ack
  );
  modport host (
    output req, wr, addr, wdata, bus_reset,
    input  rdata, ack
  );
endinterface

// file: verification/usb_endpoint_fifo_clock_cfg_tb.sv
`timescale 1ns/1ps
module usb_endpoint_fifo_clock_cfg_tb;
  import usb_ep_pkg::*;
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] m;
    logic [7:0] e;
    logic [3:0] s;
  } row_s;
  // side column: endpoint_valid, trim enable, single step, low speed
  localparam row_s ROWS [15] = '{
    '{1'b0, 8'h0e, 8'h00, 8'hff, 8'h00, 4'h8},
    '{1'b0, 8'h0f, 8'h00, 8'he0, 8'h00, 4'h8},
    '{1'b1, 8'h0f, 8'hef, 8'h00, 8'h00, 4'hf},
    '{1'b0, 8'h0f, 8'h00, 8'he0, 8'he0, 4'hf},
    '{1'b1, 8'h0f, 8'h8f, 8'h00, 8'h00, 4'hc},
    '{1'b1, 8'h0f, 8'h4f, 8'h00, 8'h00, 4'h8},
    '{1'b1, 8'h0f, 8'h2f, 8'h00, 8'h00, 4'h9},
    '{1'b1, 8'h0e, 8'hf3, 8'h00, 8'h00, 4'h9},
    '{1'b0, 8'h0e, 8'h00, 8'hff, 8'h03, 4'h9},
    '{1'b1, 8'h0e, 8'h05, 8'h00, 8'h00, 4'h1},
    '{1'b0, 8'h0e, 8'h00, 8'hff, 8'h05, 4'h1},
    '{1'b0, 8'h12, 8'h00, 8'hff, 8'h00, 4'h1},
    '{1'b0, 8'h16, 8'h00, 8'hff, 8'h00, 4'h1},
    '{1'b0, 8'h30, 8'h00, 8'hff, 8'h00, 4'h1},
    '{1'b1, 8'h0e, 8'h00, 8'h00, 8'h00, 4'h9}};
  logic        core_clk, nrst, transceiver_speed, usb_out_ready;
  logic        usb_in_valid, cmd_valid, cmd_write, cmd_bus_reset;
  logic  [7:0] usb_in_data, cmd_addr, cmd_wdata, rsp_data, usb_out_data, r;
  logic  [1:0] usb_in_endpoint, usb_out_endpoint, endpoint_pick;
  logic        low_speed_mode, trim_enable, trim_single_step, trim_low_speed;
  logic        usb_out_valid, usb_in_ready, endpoint_valid, cmd_ready;
  logic        rsp_valid;
  logic [10:0] max_in_packet, max_out_packet;
  int          err_total, checks, sz, ein, eout;
  usb_reg_if link();
  usb_ep_device usb_ep_device_inst (.core_clk(core_clk), .nrst(nrst),
    .regs(link), .transceiver_speed(transceiver_speed),
    .low_speed_mode(low_speed_mode), .trim_enable(trim_enable),
    .trim_single_step(trim_single_step), .trim_low_speed(trim_low_speed),
    .usb_out_valid(usb_out_valid), .usb_out_ready(usb_out_ready),
    .usb_out_data(usb_out_data), .usb_out_endpoint(usb_out_endpoint),
    .usb_in_valid(usb_in_valid), .usb_in_ready(usb_in_ready),
    .usb_in_data(usb_in_data), .usb_in_endpoint(usb_in_endpoint),
    .endpoint_valid(endpoint_valid), .endpoint_pick(endpoint_pick),
    .max_in_packet(max_in_packet), .max_out_packet(max_out_packet));
  usb_ep_host usb_ep_host_inst (.core_clk(core_clk), .nrst(nrst),
    .regs(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_bus_reset(cmd_bus_reset), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  usb_ep_link_sva usb_ep_link_sva_inst (.core_clk(core_clk), .nrst(nrst),
    .req(link.req), .wr(link.wr), .addr(link.addr), .wdata(link.wdata),
    .rdata(link.rdata), .ack(link.ack), .bus_reset(link.bus_reset));
  always #2.5 core_clk = ~core_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // every wait is bounded; running out ends the run as a mismatch
  task automatic until_high(ref logic sig);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sig !== 1'b1 && n < 60);
    if (n >= 60) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    until_high(cmd_ready);
    cmd_valid <= 1'b0;
    until_high(rsp_valid);
    r = rsp_data;
  endtask
  task automatic push(input logic [7:0] d);
    @(posedge core_clk);
    usb_in_valid <= 1'b1;
    usb_in_data <= d;
    until_high(usb_in_ready);
    usb_in_valid <= 1'b0;
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
  endtask
  initial begin
    {core_clk, nrst, usb_out_ready, usb_in_valid, cmd_valid} = '0;
    {cmd_write, cmd_bus_reset, usb_in_data, cmd_addr, cmd_wdata} = '0;
    usb_in_endpoint = 2'h1;
    transceiver_speed = 1'b1;
    err_total = 0;
    checks = 0;
    do_reset();
    foreach (ROWS[i]) begin
      cmd(ROWS[i].w, ROWS[i].a, ROWS[i].d);
      if (!ROWS[i].w) begin
        check(16'(r & ROWS[i].m), 16'(ROWS[i].e));
      end
      check(16'({endpoint_valid, trim_enable, trim_single_step,
                 trim_low_speed}), 16'(ROWS[i].s));
    end
    check(16'(low_speed_mode), 16'h0000);
    transceiver_speed <= 1'b0;
    @(posedge core_clk);
    check(16'(low_speed_mode), 16'h0001);
    for (int ep = 0; ep < 4; ep++) begin
      for (int k = 0; k < 4; k++) begin
        cmd(1'b1, ADDR_ENDPOINT_SELECTOR, 8'(ep));
        cmd(1'b1, ADDR_FIFO_LAYOUT, 8'(k << 1));
        sz = (ep == 0) ? 64 : (64 << ep);
        ein = (ep == 0) ? 64 : (sz >> k[1]) >> k[0];
        eout = (ep != 0 && k[1]) ? sz >> 1 : ein;
        check(16'(endpoint_pick), 16'(ep));
        check(16'(max_in_packet), 16'(ein));
        check(16'(max_out_packet), 16'(eout));
      end
    end
    cmd(1'b1, ADDR_FIFO_LAYOUT, 8'h04);
    cmd(1'b1, ADDR_EP_OUT_CSR_HIGH, 8'h02);
    check(16'(max_in_packet), 16'h0100);
    check(16'(max_out_packet), 16'h0080);
    // split endpoint one: the far side stalls while bytes pile up
    cmd(1'b1, ADDR_ENDPOINT_SELECTOR, 8'h01);
    cmd(1'b1, ADDR_FIFO_LAYOUT, 8'h04);
    for (int i = 0; i < 5; i++) begin
      push(8'ha0 + 8'(i));
    end
    cmd(1'b0, ADDR_EP_OUT_COUNT_LOW, 8'h00);
    check(16'(r), 16'h0005);
    for (int i = 0; i < 6; i++) begin
      cmd(1'b0, ADDR_DATA_PORT_BASE + 8'h01, 8'h00);
      check(16'(r), (i < 5) ? 16'(8'ha0 + 8'(i)) : 16'h0000);
    end
    cmd(1'b1, ADDR_DATA_PORT_BASE + 8'h01, 8'hc0);
    cmd(1'b1, ADDR_DATA_PORT_BASE + 8'h01, 8'hc1);
    usb_out_ready <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      until_high(usb_out_valid);
      check(16'({usb_out_endpoint, usb_out_data}),
            16'h01c0 + 16'(i));
    end
    cmd(1'b1, ADDR_ENDPOINT_SELECTOR, 8'h02);
    @(posedge core_clk);
    cmd_bus_reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmd_bus_reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    cmd(1'b0, ADDR_ENDPOINT_SELECTOR, 8'h00);
    check(16'(r), 16'h0000);
    cmd(1'b1, ADDR_CLOCK_RECOVERY, 8'hef);
    do_reset();
    cmd(1'b0, ADDR_CLOCK_RECOVERY, 8'h00);
    check(16'(r & 8'he0), 16'h0000);
    summarize();
  end
endmodule // usb_endpoint_fifo_clock_cfg_tb

// file: verification/usb_ep_link_sva.sv
`timescale 1ns/1ps
module usb_ep_link_sva (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       nrst,
  // register link
  input wire logic       req,
  input wire logic       wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack,
  input wire logic       bus_reset
);
  import usb_ep_pkg::*;
  logic [3:0] sel_q;
  logic [2:0] crec_q;
  logic       rd_ack;
  assign rd_ack = ack && !wr;
  // shadow copies, updated on the answering edge of a write
  always_ff @(posedge core_clk) begin
    if (!nrst || bus_reset) begin
      sel_q <= 4'h0;
    end else if (ack && wr && addr == ADDR_ENDPOINT_SELECTOR) begin
      sel_q <= wdata[3:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      crec_q <= RST_CLOCK_RECOVERY[7:5];
    end else if (ack && wr && addr == ADDR_CLOCK_RECOVERY) begin
      crec_q <= wdata[7:5];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_ACK_BOUND: assert property ($rose(req) |-> ##[1:8] ack)
    else $error("request left unanswered");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  AST_ACK_CAUSE: assert property (ack |-> $past(req))
    else $error("answer without request");
  AST_REQ_HOLD: assert property (req && !ack |=>
    req && $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("request changed before answer");
  AST_SEL_READ: assert property (rd_ack &&
    addr == ADDR_ENDPOINT_SELECTOR |-> rdata == {4'h0, sel_q})
    else $error("selector read mismatch");
  AST_IDX_RESERVED: assert property (rd_ack &&
    sel_q > LAST_ENDPOINT &&
    addr inside {[ADDR_EP_IN_CSR_HIGH:ADDR_EP_OUT_COUNT_HIGH]}
    |-> rdata == 8'h00)
    else $error("indexed read with reserved selector not zero");
  AST_UNMAPPED: assert property (rd_ack && addr > ADDR_DATA_PORT_LAST
    |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CLOCK_RECOVERY_CONTROL_WRITE: assert property (req && wr &&
    addr == ADDR_CLOCK_RECOVERY |-> wdata[4:0] == 5'b01111)
    else $error("reserved recovery bits written wrong");
  AST_CLOCK_RECOVERY_CONTROL_READ: assert property (rd_ack &&
    addr == ADDR_CLOCK_RECOVERY |-> rdata[7:5] == crec_q)
    else $error("recovery control read mismatch");
  cover property (rd_ack && sel_q > LAST_ENDPOINT);
  cover property (ack && wr && addr == ADDR_FIFO_LAYOUT);
  cover property (bus_reset ##1 !bus_reset);
endmodule // usb_ep_link_sva
